/* socket_force_event_logic.sv */
// apb register block: force-event injection into socket event and present-state state
`timescale 1ns/1ps
`include "socket_force_defs.svh"
// What this block does
// - writing retest bit reruns interrogation, refreshes present state, re-enables power control
// - force voltage bits 13..10 write card voltage capability bits
// - any force voltage bit written one disables power control until retest
// - bit 9 writes the invalid supply request flag
// - bit 8 writes the possible lost write flag
// - bit 7 writes the unknown card flag
// - bits 5 and 4 write cardbus and sixteen bit type flags
// - bit 3 writes power change event; socket powered state unchanged
// - bits 2 and 1 write detect change events; live detect bits unchanged
// - bit 0 writes status change event; live status pin bit unchanged
// - bits 31..15 of force register read zero
// - bit 6 of force register reads zero, writes ignored
// - force register decoded at offset 0Ch; write-only bits read zero
// - socket yy and xx capability bits read zero unless forced
// - context bits cleared by global reset only when pme enabled
module socket_force_event_logic
	import socket_force_pkg::*;
(
	input  wire logic                         clk_sys,
	input  wire logic                         rst_n,
	input  wire logic                         global_reset_n,
	input  wire logic                         bus_reset_n,
	input  wire logic                         pme_enable,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire socket_force_pkg::addr_t      paddr,
	input  wire socket_force_pkg::word_t      pwdata,
	input  wire logic [3:0]                   pstrb,
	input  wire logic                         detect_one_live,
	input  wire logic                         detect_two_live,
	input  wire logic                         status_change_live,
	input  wire logic                         socket_powered_state,
	input  wire socket_force_pkg::word_t      probe_result,
	output logic                              pready,
	output logic                              pslverr,
	output socket_force_pkg::word_t           prdata,
	output logic                              power_ctrl_enable,
	output socket_force_pkg::event_t          event_flags,
	output socket_force_pkg::word_t           present_state,
	output logic                              irq
);
	import socket_force_pkg::*;

	// timeline of a force write, counted from the setup cycle c0:
	//   c1  access cycle, pready high, the write is accepted at its closing edge
	//   c2  captured word and lane mask sit in inject_*_reg and lane_reg
	//   c3  present state, event flags and power-control enable show the result
	// a retest bit in that write starts the sequencer at the end of c2; its done
	// pulse lands in c5 and the refreshed state is visible in c6
	// a second force write may follow at once: capture registers are reloaded
	// each cycle, so nothing of an older write can be applied twice
	// reads decode in the setup cycle and hold prdata through the access
	// cycle; the force register itself always reads back as zero
	// pstrb gates which byte lanes of a force write take effect

	// bus state
	logic  pready_reg;
	logic  pready_next;
	logic  pslverr_reg;
	logic  pslverr_next;
	word_t prdata_reg;
	word_t prdata_next;

	// captured write, applied one cycle later
	logic  inject_reg;
	logic  inject_next;
	word_t inject_data_reg;
	word_t inject_data_next;

	// socket state
	word_t  pstate_reg;
	word_t  pstate_next;
	event_t events_reg;
	event_t events_next;
	logic   pwr_en_reg;
	logic   pwr_en_next;
	logic   irq_out_reg;

	// sequencer and interrupt wiring
	logic                      retest_start;
	logic                      retest_busy;
	logic                      retest_done;
	logic [`IRQ_SRC_WIDTH-1:0] irq_events;
	logic [`IRQ_SRC_WIDTH-1:0] irq_clear;
	logic                      irq_en_we;
	logic [`IRQ_SRC_WIDTH-1:0] irq_status;
	logic [`IRQ_SRC_WIDTH-1:0] irq_enable;
	logic                      irq_line;

	// context reset: global reset only under pme, otherwise either reset
	logic ctx_clear;
	logic setup;
	logic wr_access;
	logic force_hit;
	word_t wmask;

	always_comb begin
		ctx_clear = ~global_reset_n | (~pme_enable & ~bus_reset_n);
		setup     = psel & ~penable;
		wr_access = psel & penable & pready_reg & pwrite;
		force_hit = wr_access & (paddr == `OFS_EVENT_INJECTION);
	end

	// byte strobes widened to a bit mask, one lane per strobe
	genvar lane_i;
	for (lane_i = 0; lane_i < 4; lane_i++) begin : g_lane
		assign wmask[lane_i*8 +: 8] = {8{pstrb[lane_i]}};
	end

	// apb slave: no wait states, pready high in the access cycle only
	always_comb begin
		pready_next = setup;
		pslverr_next = `PSLVERR_NONE; // no slave error: unmapped reads give zero
		prdata_next = prdata_reg;
		if (setup && !pwrite) begin
			case (paddr)
				`OFS_EVENT_FLAGS:     prdata_next = {28'h000_0000, events_reg};
				`OFS_PRESENT_STATE:   prdata_next = pstate_reg;
				`OFS_EVENT_INJECTION: prdata_next = 32'h0000_0000;
				`OFS_IRQ_STATUS:      prdata_next = {29'h0000_0000, irq_status};
				`OFS_IRQ_ENABLE:      prdata_next = {29'h0000_0000, irq_enable};
				`OFS_SOCKET_CONTROL:  prdata_next = {31'h0000_0000, pwr_en_reg};
				default:              prdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
		end else begin
			pready_reg  <= pready_next;
			pslverr_reg <= pslverr_next;
			prdata_reg  <= prdata_next;
		end
	end

	// capture only writable bits; nothing of the force register persists
	always_comb begin
		inject_next      = force_hit;
		inject_data_next = pwdata & wmask & `FORCE_WRITE_MASK;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			inject_reg      <= 1'b0;
			inject_data_reg <= 32'h0000_0000;
		end else begin
			inject_reg      <= inject_next;
			inject_data_reg <= inject_data_next;
		end
	end

	// write mask as seen one cycle later; lanes not strobed leave bits alone
	// the mask is cleared outside a force write so a stale lane cannot
	// re-apply old data when inject_reg is low
	logic [31:0] lane_reg;
	logic [31:0] lane_next;
	always_comb begin
		lane_next = force_hit ? wmask : 32'h0000_0000;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			lane_reg <= 32'h0000_0000;
		end else begin
			lane_reg <= lane_next;
		end
	end

	assign retest_start = inject_reg & inject_data_reg[`BIT_VS_RETEST];

	// priority inside one cycle: live pins first, then a finished
	// interrogation, then a force write; a force write that lands in the same
	// cycle as the interrogation result therefore wins, which lets software
	// correct a probe it does not trust
	// power control drops on any forced voltage bit written as one; only a
	// finished interrogation or a context clear raises it again
	// the live pin bits are never forced; they lag their pins by one cycle
	// present state, events and power-control enable
	always_comb begin
		logic [31:0] pmask;
		pmask       = lane_reg & `PSTATE_FORCE_MASK;
		pstate_next = pstate_reg;
		events_next = events_reg;
		pwr_en_next = pwr_en_reg;
		// live pins always tracked; forcing never touches them
		pstate_next[`BIT_STATUS_CHANGE] = status_change_live;
		pstate_next[`BIT_DETECT_ONE]    = detect_one_live;
		pstate_next[`BIT_DETECT_TWO]    = detect_two_live;
		pstate_next[`BIT_POWER_EVENT]   = socket_powered_state;
		if (retest_done) begin
			// interrogation result refreshes capability and type bits
			pstate_next = (pstate_next & ~`PSTATE_FORCE_MASK) |
				(probe_result & `PSTATE_FORCE_MASK);
			pwr_en_next = 1'b1;
		end
		if (inject_reg) begin
			// bits 13..4 excluding 6
			pstate_next = (pstate_next & ~pmask) | (inject_data_reg & pmask);
			// socket yy/xx capability forced alongside the card bits
			if (lane_reg[`BIT_YY_VOLT]) begin
				pstate_next[`BIT_SOCKET_YY] = inject_data_reg[`BIT_YY_VOLT];
			end
			if (lane_reg[`BIT_XX_VOLT]) begin
				pstate_next[`BIT_SOCKET_XX] = inject_data_reg[`BIT_XX_VOLT];
			end
			if (lane_reg[0]) begin
				events_next = inject_data_reg[3:0];
			end
			if (|inject_data_reg[`BIT_YY_VOLT:`BIT_FIVE_VOLT]) begin
				pwr_en_next = 1'b0;
			end
		end
	end

	// the bus and global resets are sampled here rather than used as
	// asynchronous clears, so a glitch on either cannot corrupt state between
	// clock edges; the cost is one cycle of latency on the clear
	// while pme is enabled only the global reset reaches these bits
	// context bits use their own reset qualifier; pme keeps them across bus reset
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pstate_reg <= `PSTATE_RESET;
			events_reg <= 4'h0;
			pwr_en_reg <= 1'b1;
		end else if (ctx_clear) begin
			pstate_reg <= `PSTATE_RESET;
			events_reg <= 4'h0;
			pwr_en_reg <= 1'b1;
		end else begin
			pstate_reg <= pstate_next;
			events_reg <= events_next;
			pwr_en_reg <= pwr_en_next;
		end
	end

	// the power-off source fires on the cycle the enable falls, so a force
	// write that finds power control already off raises no second event
	// clear and enable writes act at the accepting edge, like any register
	// every source is sticky until written one to the clear register
	// interrupt sources: injection, retest done, power control dropped
	always_comb begin
		irq_events[`IRQ_SRC_INJECT]  = inject_reg;
		irq_events[`IRQ_SRC_RETEST]  = retest_done;
		irq_events[`IRQ_SRC_PWR_OFF] = pwr_en_reg & ~pwr_en_next;
		irq_clear = '0;
		if (wr_access && paddr == `OFS_IRQ_CLEAR) begin
			irq_clear = pwdata[`IRQ_SRC_WIDTH-1:0];
		end
		irq_en_we = wr_access & (paddr == `OFS_IRQ_ENABLE);
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq_out_reg <= 1'b0;
		end else begin
			irq_out_reg <= irq_line;
		end
	end

	// the sequencer ignores a start while busy; software must wait for the
	// retest-done interrupt before asking for another interrogation
	// busy is kept for debug visibility and is otherwise unused
	retest_sequencer u_retest (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.start   (retest_start),
		.busy    (retest_busy),
		.done    (retest_done)
	);

	// enable write data comes straight from the bus; irq_line is already a
	// flop, irq_out_reg adds one more so the pin has a fixed two-cycle lag
	irq_status_bank u_irq (
		.clk_sys      (clk_sys),
		.rst_n        (rst_n),
		.event_pulse  (irq_events),
		.clear_bits   (irq_clear),
		.enable_we    (irq_en_we),
		.enable_wdata (pwdata[`IRQ_SRC_WIDTH-1:0]),
		.status       (irq_status),
		.enable       (irq_enable),
		.irq          (irq_line)
	);

	// outputs straight from flip-flops
	assign pready            = pready_reg;
	assign pslverr           = pslverr_reg;
	assign prdata            = prdata_reg;
	assign power_ctrl_enable = pwr_en_reg;
	assign event_flags       = events_reg;
	assign present_state     = pstate_reg;
	assign irq               = irq_out_reg;
endmodule

/* socket_force_defs.svh */
// register offsets, field positions and reset values of the socket force-event block
`ifndef SOCKET_FORCE_DEFS_SVH
`define SOCKET_FORCE_DEFS_SVH
`define OFS_EVENT_INJECTION   12'h00C
`define OFS_PRESENT_STATE     12'h008
`define OFS_EVENT_FLAGS       12'h000
`define OFS_IRQ_STATUS        12'h020
`define OFS_IRQ_ENABLE        12'h024
`define OFS_IRQ_CLEAR         12'h028
`define OFS_SOCKET_CONTROL    12'h02C
`define BIT_VS_RETEST         14
`define BIT_YY_VOLT           13
`define BIT_XX_VOLT           12
`define BIT_THREE_VOLT        11
`define BIT_FIVE_VOLT         10
`define BIT_INVALID_SUPPLY    9
`define BIT_LOST_WRITE        8
`define BIT_UNKNOWN_CARD      7
`define BIT_CARDBUS_TYPE      5
`define BIT_SIXTEEN_BIT_TYPE  4
`define BIT_POWER_EVENT       3
`define BIT_DETECT_TWO        2
`define BIT_DETECT_ONE        1
`define BIT_STATUS_CHANGE     0
`define BIT_SOCKET_YY         31
`define BIT_SOCKET_XX         30
`define BIT_SOCKET_THREE      29
`define BIT_SOCKET_FIVE       28
`define FORCE_WRITE_MASK      32'h0000_7FBF
`define PSTATE_FORCE_MASK     32'h0000_3FB0
`define EVENT_FORCE_MASK      4'hF
`define PSTATE_RESET          32'h3000_0000
`define IRQ_SRC_COUNT         3
`define IRQ_SRC_WIDTH         3
`define IRQ_SRC_INJECT        0
`define IRQ_SRC_RETEST        1
`define IRQ_SRC_PWR_OFF       2
`define PSLVERR_NONE          1'b0
`endif

/* socket_force_pkg.sv */
// types shared by the socket force-event block
package socket_force_pkg;
	typedef logic [31:0] word_t;
	typedef logic [11:0] addr_t;
	typedef logic [3:0]  event_t;
	typedef enum logic [1:0] {
		seq_idle,
		seq_probe,
		seq_update
	} retest_state_e;
endpackage

/* retest_sequencer.sv */
// hook that runs a card re-interrogation and reports completion
`timescale 1ns/1ps
module retest_sequencer
	import socket_force_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic start,
	output logic      busy,
	output logic      done
);
	import socket_force_pkg::*;

	retest_state_e state_reg;
	retest_state_e state_next;
	logic          done_reg;
	logic          done_next;

	// probe for one cycle, then publish the result
	always_comb begin
		state_next = state_reg;
		done_next  = 1'b0;
		case (state_reg)
			seq_idle: begin
				if (start) begin
					state_next = seq_probe;
				end
			end
			seq_probe: begin
				state_next = seq_update;
			end
			seq_update: begin
				state_next = seq_idle;
				done_next  = 1'b1;
			end
			default: begin
				state_next = seq_idle;
			end
		endcase
	end

	// a new start while busy is ignored; the run in flight covers it
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= seq_idle;
			done_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			done_reg  <= done_next;
		end
	end

	assign busy = (state_reg != seq_idle);
	assign done = done_reg;
endmodule

/* irq_status_bank.sv */
// sticky interrupt status with enable and write-one-to-clear
`timescale 1ns/1ps
`include "socket_force_defs.svh"
module irq_status_bank
	import socket_force_pkg::*;
(
	input  wire logic                       clk_sys,
	input  wire logic                       rst_n,
	input  wire logic [`IRQ_SRC_WIDTH-1:0]  event_pulse,
	input  wire logic [`IRQ_SRC_WIDTH-1:0]  clear_bits,
	input  wire logic                       enable_we,
	input  wire logic [`IRQ_SRC_WIDTH-1:0]  enable_wdata,
	output logic      [`IRQ_SRC_WIDTH-1:0]  status,
	output logic      [`IRQ_SRC_WIDTH-1:0]  enable,
	output logic                            irq
);
	import socket_force_pkg::*;

	logic [`IRQ_SRC_WIDTH-1:0] status_reg;
	logic [`IRQ_SRC_WIDTH-1:0] status_next;
	logic [`IRQ_SRC_WIDTH-1:0] enable_reg;
	logic [`IRQ_SRC_WIDTH-1:0] enable_next;
	logic                      irq_reg;
	logic                      irq_next;

	// per source: set beats clear so no event is lost
	genvar gi;
	for (gi = 0; gi < `IRQ_SRC_COUNT; gi++) begin : g_src
		always_comb begin
			status_next[gi] = event_pulse[gi] | (status_reg[gi] & ~clear_bits[gi]);
		end
	end

	// enable write and level interrupt
	always_comb begin
		enable_next = enable_we ? enable_wdata : enable_reg;
		irq_next    = |(status_next & enable_next);
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			status_reg <= '0;
			enable_reg <= '0;
			irq_reg    <= 1'b0;
		end else begin
			status_reg <= status_next;
			enable_reg <= enable_next;
			irq_reg    <= irq_next;
		end
	end

	assign status = status_reg;
	assign enable = enable_reg;
	assign irq    = irq_reg;
endmodule

/* socket_force_chk.sv */
// concurrent checks on the ports of the socket force-event block
`timescale 1ns/1ps
module socket_force_chk (
	input wire logic                    clk_sys,
	input wire logic                    rst_n,
	input wire logic                    global_reset_n,
	input wire logic                    bus_reset_n,
	input wire logic                    psel,
	input wire logic                    penable,
	input wire logic                    pwrite,
	input wire socket_force_pkg::addr_t paddr,
	input wire socket_force_pkg::word_t pwdata,
	input wire logic [3:0]              pstrb,
	input wire logic                    detect_one_live,
	input wire logic                    detect_two_live,
	input wire logic                    status_change_live,
	input wire logic                    socket_powered_state,
	input wire logic                    pready,
	input wire logic                    pslverr,
	input wire socket_force_pkg::word_t prdata,
	input wire logic                    power_ctrl_enable,
	input wire socket_force_pkg::event_t event_flags,
	input wire socket_force_pkg::word_t present_state
);
	import socket_force_pkg::*;
	word_t wd_reg;
	word_t wd_next;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// last accepted force word, so later cycles can compare against it
	always_comb begin
		wd_next = wd_reg;
		if (psel && penable && pready && pwrite && paddr == 12'h00C)
			wd_next = pwdata;
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			wd_reg <= 32'h0000_0000;
		else
			wd_reg <= wd_next;
	end
	sequence force_wr;
		psel && penable && pready && pwrite && paddr == 12'h00C;
	endsequence
	sequence lanes_full;
		pstrb[1:0] == 2'b11 && !pwdata[14];
	endsequence
	a_setup_gets_ready: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	a_ready_in_access: assert property (pready |-> psel && penable)
		else $error("pready outside access");
	a_no_slave_err: assert property (!pslverr)
		else $error("pslverr raised");
	a_force_reads_zero: assert property (
		psel && penable && pready && !pwrite && paddr == 12'h00C |-> prdata == 32'h0000_0000)
		else $error("force register read not zero");
	a_volt_cuts_power: assert property (
		force_wr ##0 lanes_full ##0 (pwdata[13:10] != 4'h0) |-> ##[1:3] !power_ctrl_enable)
		else $error("power control stayed enabled");
	a_retest_restores: assert property (
		force_wr ##0 (pstrb[1] && pwdata[14]) |-> ##[2:8] power_ctrl_enable)
		else $error("retest did not re-enable power");
	a_pstate_forced: assert property (force_wr ##0 lanes_full |-> ##[1:2]
		({present_state[13:7], present_state[5:4]} == {wd_reg[13:7], wd_reg[5:4]}))
		else $error("present state not forced");
	a_events_forced: assert property (
		force_wr ##0 pstrb[0] |-> ##[1:2] event_flags == wd_reg[3:0])
		else $error("event flags not forced");
	a_live_bits_kept: assert property (
		$past(rst_n) && $past(global_reset_n) && $past(bus_reset_n) |-> present_state[3:0] ==
		$past({socket_powered_state, detect_two_live, detect_one_live, status_change_live}))
		else $error("live bits disturbed");
endmodule
bind socket_force_event_logic socket_force_chk u_chk (.clk_sys, .rst_n, .global_reset_n,
	.bus_reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .detect_one_live,
	.detect_two_live, .status_change_live, .socket_powered_state, .pready, .pslverr,
	.prdata, .power_ctrl_enable, .event_flags, .present_state);

/* socket_force_event_logic_tb.sv */
// self-checking bench for the socket force-event block
`timescale 1ns/1ps
module socket_force_event_logic_tb;
	import socket_force_pkg::*;
	typedef struct {word_t exp; word_t mask; string what;} note_s;
	note_s notes[$];
	logic clk_sys = 0, rst_n = 0, global_reset_n = 1, bus_reset_n = 1, pme_enable = 0;
	logic psel = 0, penable = 0, pwrite = 0;
	logic detect_one_live = 0, detect_two_live = 0, status_change_live = 0;
	logic socket_powered_state = 0;
	logic [3:0] pstrb = 4'hF;
	addr_t paddr = '0;
	word_t pwdata = '0, probe_result = '0, psm = '0;
	logic pready, pslverr, power_ctrl_enable, irq, pce = 1;
	word_t prdata, present_state;
	event_t event_flags, evm = '0;
	int err_total = 0, checks_done = 0;
	socket_force_event_logic uut (.clk_sys, .rst_n, .global_reset_n, .bus_reset_n,
		.pme_enable, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .detect_one_live,
		.detect_two_live, .status_change_live, .socket_powered_state, .probe_result,
		.pready, .pslverr, .prdata, .power_ctrl_enable, .event_flags, .present_state, .irq);
	initial begin
		forever #20 clk_sys = ~clk_sys;
	end
	task automatic chk(input string what, input word_t seen, input word_t exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s exp %h seen %h", what, exp, seen);
		end
	endtask
	// one apb transfer; request held until pready is seen at an edge
	task automatic apb(input logic wr, input addr_t a, input word_t d, input logic [3:0] s);
		@(posedge clk_sys);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk_sys);
		penable <= 1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		psel <= 0;
		penable <= 0;
	endtask
	task automatic rd(input addr_t a, input word_t e, input word_t m, input string w);
		notes.push_back('{e, m, w});
		apb(0, a, 32'h0000_0000, 4'hF);
	endtask
	// force write plus the expected side effects on the model
	task automatic wr(input word_t d, input logic [3:0] s);
		apb(1, 12'h00C, d, s);
		if (s[0]) begin
			{psm[7], psm[5:4]} = {d[7], d[5:4]};
			evm = d[3:0];
		end
		if (s[1]) begin
			psm[13:8] = d[13:8];
			if (d[13:10] != 4'h0)
				pce = 0;
			if (d[14]) begin
				psm = probe_result & 32'h0000_3FB0;
				pce = 1;
			end
		end
		repeat (6) @(posedge clk_sys);
	endtask
	task automatic vfy();
		rd(12'h008, psm | {socket_powered_state, detect_two_live, detect_one_live,
			status_change_live}, 32'h0000_3FFF, "pstate");
		rd(12'h000, evm, 32'h0000_000F, "events");
		rd(12'h02C, pce, 32'h0000_0001, "pwr_en");
	endtask
	// reads are compared as they complete, oldest note first
	always @(posedge clk_sys) begin
		if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0) begin
			note_s n;
			n = notes.pop_front();
			chk(n.what, prdata & n.mask, n.exp & n.mask);
		end
	end
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (6000) @(posedge clk_sys);
		err_total++;
		report_and_stop();
	end
	initial begin
		void'($urandom(89092));
		repeat (10) @(posedge clk_sys);
		rst_n <= 1;
		{socket_powered_state, detect_two_live, detect_one_live, status_change_live} <= $urandom;
		rd(12'h008, 32'h3000_0000, 32'hFFFF_FFF0, "pstate_rst");
		apb(1, 12'h024, 32'h0000_0007, 4'hF);
		for (int i = 0; i < 10; i++) begin
			wr($urandom & 32'hFFFF_BFFF, $urandom);
			vfy();
		end
		wr(32'h0000_3000, 4'hF);
		rd(12'h008, 32'hC000_0000, 32'hC000_0000, "socket_cap");
		probe_result <= $urandom;
		wr(32'h0000_4000, 4'hF);
		vfy();
		rd(12'h020, 32'h0000_0007, 32'h0000_0007, "irq_stat");
		chk("irq_set", irq, 1'b1);
		apb(1, 12'h028, 32'h0000_0007, 4'hF);
		rd(12'h020, 32'h0000_0000, 32'h0000_0007, "irq_clr");
		chk("irq_clr", irq, 1'b0);
		apb(1, 12'h024, 32'h0000_0000, 4'hF);
		wr(32'h0000_0400, 4'hF);
		rd(12'h020, 32'h0000_0005, 32'h0000_0007, "irq_mask");
		chk("irq_mask", irq, 1'b0);
		rd(12'h00C, 32'h0000_0000, 32'hFFFF_FFFF, "force_rd");
		rd(12'h040, 32'h0000_0000, 32'hFFFF_FFFF, "unmapped");
		pme_enable <= 1;
		bus_reset_n <= 0;
		repeat (2) @(posedge clk_sys);
		bus_reset_n <= 1;
		vfy();
		global_reset_n <= 0;
		repeat (2) @(posedge clk_sys);
		global_reset_n <= 1;
		{psm, evm, pce} = {32'h0000_0000, 4'h0, 1'b1};
		vfy();
		pme_enable <= 0;
		wr(32'h0000_3FBF, 4'hF);
		bus_reset_n <= 0;
		repeat (2) @(posedge clk_sys);
		bus_reset_n <= 1;
		{psm, evm, pce} = {32'h0000_0000, 4'h0, 1'b1};
		vfy();
		repeat (4) @(posedge clk_sys);
		report_and_stop();
	end
endmodule
